// >>> pwe_params.svh
// pwe register map, field positions and reset values
`ifndef PWE_PARAMS_SVH
`define PWE_PARAMS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define PWE_IDX_GLB_FLAG 6'h00
`define PWE_IDX_GLB_EN 6'h04
`define PWE_IDX_STS_THREE 6'h08
`define PWE_IDX_STS_TWO 6'h09
`define PWE_IDX_STS_ONE 6'h0a
`define PWE_IDX_HOLE 6'h0b
`define PWE_IDX_EN_THREE 6'h0c
`define PWE_IDX_EN_TWO 6'h0d
`define PWE_IDX_EN_ONE 6'h0e
`define PWE_IDX_IRQ_STS 6'h20
`define PWE_IDX_IRQ_CLR 6'h21
`define PWE_IDX_IRQ_EN 6'h22

// ----------------------------------------
// reset values
// ----------------------------------------
`define PWE_RST_BYTE 8'h00
`define PWE_RST_WORD 32'h0000_0000
`define PWE_RST_IRQ 2'h0

// ----------------------------------------
// writable masks and field positions
// ----------------------------------------
`define PWE_MASK_EN_ONE 8'hfe
`define PWE_MASK_EN_THREE 8'h0f
`define PWE_BIT_GLB 0
`define PWE_BIT_FAN_ONE 6
`define PWE_BIT_FAN_TWO 7
`define PWE_IRQ_BIT_EVENT 0
`define PWE_IRQ_BIT_WAKE 1
`define PWE_IRQ_W 2

`endif

// >>> pwe_pkg.sv
// pwe shared types
package pwe_pkg;

	// ----------------------------------------
	// bus handshake states, one-hot
	// ----------------------------------------
	typedef enum logic [1:0] {
		PWE_BUS_IDLE = 2'b01,
		PWE_BUS_ACK  = 2'b10
	} pwe_bus_state_t;

	typedef logic [7:0] pwe_byte_t;

endpackage

// >>> pwe_sticky_bits.sv
// pwe sticky flag vector, set wins over clear
`timescale 1ns/1ps
module pwe_sticky_bits #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// events and clears
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic [WIDTH-1:0] clr_bits,
	// flags
	output logic      [WIDTH-1:0] bits_r
);

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("pwe_sticky_bits: WIDTH must be at least 1");
		end
	endgenerate

	// an event in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (rst) begin
			bits_r <= '0;
		end else begin
			bits_r <= (bits_r & ~clr_bits) | set_bits;
		end
	end

endmodule // pwe_sticky_bits

// >>> pwe_wake_event_top.sv
// pwe wake event logic with avalon-mm register slave
`timescale 1ns/1ps
`include "pwe_params.svh"

// Notes on behaviour
// - writing one clears a status bit
// - writing zero leaves status bit unchanged
// - wake status reset only by standby power-on reset
// - events set status regardless of any enable
// - group two status holds pins ten-seventeen
// - group one: reserved, ring, keys, fans
// - fan status never set in gpio mode
// - leaving tach mode clears fan status
// - enable, status and global enable drive wake
// - disabled source still recorded, not driving
// - wake enables reset only by standby power-on
// - reserved hole after status reads zero
// - global enable gates the wake output
// - global flag write-one-clear stops wake
module pwe_wake_event_top #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              standby_power_on_reset,
	// avalon-mm slave, byte address
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// wake sources, asynchronous pins
	input  wire logic [7:0]        general_pin_group_one,
	input  wire logic [3:0]        general_pin_twenty,
	input  wire logic              ring_indicate_one,
	input  wire logic              ring_indicate_two,
	input  wire logic              keyboard_wake_source,
	input  wire logic              mouse_wake_source,
	input  wire logic              specific_key_wake,
	input  wire logic              fan_speed_input_one,
	input  wire logic              fan_speed_input_two,
	// shared pin function, same clock domain
	input  wire logic [1:0]        fan_pin_tach_mode,
	// outputs
	output logic                   wake_request_out_n,
	output logic                   irq
);

	localparam int SRC_W = 19;

	generate
		if (ADDR_W < 8) begin : g_bad_addr
			$error("pwe_wake_event_top: ADDR_W must be at least 8");
		end
	endgenerate

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic idx_is(input logic [5:0] idx, input logic [5:0] want);
		idx_is = (idx == want);
	endfunction

	function automatic pwe_pkg::pwe_byte_t w1c(input logic go, input pwe_pkg::pwe_byte_t d);
		w1c = go ? d : `PWE_RST_BYTE;
	endfunction

	// ----------------------------------------
	// standby power-on reset synchroniser
	// ----------------------------------------
	logic por_a_r;
	logic por_b_r;

	always_ff @(posedge clk) begin
		por_a_r <= standby_power_on_reset;
		por_b_r <= por_a_r;
	end

	// ----------------------------------------
	// source synchroniser and edge detect
	// ----------------------------------------
	logic [SRC_W-1:0] src_raw;
	logic [SRC_W-1:0] src_a_r;
	logic [SRC_W-1:0] src_b_r;
	logic [SRC_W-1:0] src_c_r;
	logic [SRC_W-1:0] src_rise;

	assign src_raw = {general_pin_twenty,
		fan_speed_input_two, fan_speed_input_one, specific_key_wake,
		mouse_wake_source, keyboard_wake_source, ring_indicate_one,
		ring_indicate_two, general_pin_group_one};

	// a wake event is the rising edge of a synchronised source
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			src_a_r <= '0;
			src_b_r <= '0;
			src_c_r <= '0;
		end else begin
			src_a_r <= src_raw;
			src_b_r <= src_a_r;
			src_c_r <= src_b_r;
		end
	end

	assign src_rise = src_b_r & ~src_c_r;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	pwe_pkg::pwe_bus_state_t bus_state_r;
	logic [5:0]              reg_idx;
	logic                    wr_go;
	pwe_pkg::pwe_byte_t      wr_byte;
	logic [31:0]             rd_nxt;

	assign reg_idx = avs_address[7:2];
	assign wr_byte = avs_writedata[7:0];
	// only the completing cycle writes, and only with lane zero enabled
	assign wr_go = (bus_state_r == pwe_pkg::PWE_BUS_ACK) & avs_write & avs_byteenable[0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_state_r     <= pwe_pkg::PWE_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state_r)
				pwe_pkg::PWE_BUS_IDLE: begin
					if (avs_read | avs_write) begin
						bus_state_r     <= pwe_pkg::PWE_BUS_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				pwe_pkg::PWE_BUS_ACK: begin
					bus_state_r     <= pwe_pkg::PWE_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state_r     <= pwe_pkg::PWE_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// register write strobes
	// ----------------------------------------
	logic wr_glb_flag;
	logic wr_glb_en;
	logic wr_sts3;
	logic wr_sts2;
	logic wr_sts1;
	logic wr_en3;
	logic wr_en2;
	logic wr_en1;
	logic wr_irq_clr;
	logic wr_irq_en;

	assign wr_glb_flag = wr_go & idx_is(reg_idx, `PWE_IDX_GLB_FLAG);
	assign wr_glb_en   = wr_go & idx_is(reg_idx, `PWE_IDX_GLB_EN);
	assign wr_sts3     = wr_go & idx_is(reg_idx, `PWE_IDX_STS_THREE);
	assign wr_sts2     = wr_go & idx_is(reg_idx, `PWE_IDX_STS_TWO);
	assign wr_sts1     = wr_go & idx_is(reg_idx, `PWE_IDX_STS_ONE);
	assign wr_en3      = wr_go & idx_is(reg_idx, `PWE_IDX_EN_THREE);
	assign wr_en2      = wr_go & idx_is(reg_idx, `PWE_IDX_EN_TWO);
	assign wr_en1      = wr_go & idx_is(reg_idx, `PWE_IDX_EN_ONE);
	assign wr_irq_clr  = wr_go & idx_is(reg_idx, `PWE_IDX_IRQ_CLR);
	assign wr_irq_en   = wr_go & idx_is(reg_idx, `PWE_IDX_IRQ_EN);

	// ----------------------------------------
	// fan pin function tracking
	// ----------------------------------------
	logic [1:0] tach_prev_r;
	logic [1:0] tach_leave;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tach_prev_r <= 2'h0;
		end else begin
			tach_prev_r <= fan_pin_tach_mode;
		end
	end

	assign tach_leave = tach_prev_r & ~fan_pin_tach_mode;

	// ----------------------------------------
	// wake status groups
	// ----------------------------------------
	pwe_pkg::pwe_byte_t ev_one;
	pwe_pkg::pwe_byte_t ev_two;
	pwe_pkg::pwe_byte_t ev_three;
	pwe_pkg::pwe_byte_t clr_one;
	pwe_pkg::pwe_byte_t clr_two;
	pwe_pkg::pwe_byte_t clr_three;
	pwe_pkg::pwe_byte_t sts_one;
	pwe_pkg::pwe_byte_t sts_two;
	pwe_pkg::pwe_byte_t sts_three;

	assign ev_two = src_rise[7:0];

	// bit zero stays reserved; fans only count in tach mode
	always_comb begin
		ev_one = {src_rise[14:8], 1'b0};
		ev_one[`PWE_BIT_FAN_ONE] = src_rise[13] & fan_pin_tach_mode[0];
		ev_one[`PWE_BIT_FAN_TWO] = src_rise[14] & fan_pin_tach_mode[1];
	end

	assign ev_three = {4'h0, src_rise[18:15]};

	// written zeros clear nothing
	assign clr_two   = w1c(wr_sts2, wr_byte);
	assign clr_three = w1c(wr_sts3, wr_byte);

	always_comb begin
		clr_one = w1c(wr_sts1, wr_byte);
		clr_one[`PWE_BIT_FAN_ONE] = clr_one[`PWE_BIT_FAN_ONE] | tach_leave[0];
		clr_one[`PWE_BIT_FAN_TWO] = clr_one[`PWE_BIT_FAN_TWO] | tach_leave[1];
	end

	// only standby power-on resets the wake state; sys_rst leaves it
	pwe_sticky_bits #(
		.WIDTH (8)
	) u_sts_one (
		.clk      (clk),
		.rst      (por_b_r),
		.set_bits (ev_one),
		.clr_bits (clr_one),
		.bits_r   (sts_one)
	);

	pwe_sticky_bits #(
		.WIDTH (8)
	) u_sts_two (
		.clk      (clk),
		.rst      (por_b_r),
		.set_bits (ev_two),
		.clr_bits (clr_two),
		.bits_r   (sts_two)
	);

	pwe_sticky_bits #(
		.WIDTH (8)
	) u_sts_three (
		.clk      (clk),
		.rst      (por_b_r),
		.set_bits (ev_three),
		.clr_bits (clr_three),
		.bits_r   (sts_three)
	);

	// ----------------------------------------
	// wake enables
	// ----------------------------------------
	pwe_pkg::pwe_byte_t en_one_r;
	pwe_pkg::pwe_byte_t en_two_r;
	pwe_pkg::pwe_byte_t en_three_r;
	logic               glb_en_r;

	always_ff @(posedge clk) begin
		if (por_b_r) begin
			en_one_r   <= `PWE_RST_BYTE;
			en_two_r   <= `PWE_RST_BYTE;
			en_three_r <= `PWE_RST_BYTE;
			glb_en_r   <= 1'b0;
		end else begin
			if (wr_en1) begin
				en_one_r <= wr_byte & `PWE_MASK_EN_ONE;
			end
			if (wr_en2) begin
				en_two_r <= wr_byte;
			end
			if (wr_en3) begin
				en_three_r <= wr_byte & `PWE_MASK_EN_THREE;
			end
			if (wr_glb_en) begin
				glb_en_r <= wr_byte[`PWE_BIT_GLB];
			end
		end
	end

	// ----------------------------------------
	// global flag and wake output
	// ----------------------------------------
	logic any_enabled;
	logic any_prev_r;
	logic glb_flag;
	logic wake_act;

	// disabled sources stay recorded but drop out here
	assign any_enabled = |({sts_one & en_one_r, sts_two & en_two_r,
		sts_three & en_three_r});

	always_ff @(posedge clk) begin
		if (por_b_r) begin
			any_prev_r <= 1'b0;
		end else begin
			any_prev_r <= any_enabled;
		end
	end

	// edge-set so a write-one clear sticks while sources stay pending
	pwe_sticky_bits #(
		.WIDTH (1)
	) u_glb_flag (
		.clk      (clk),
		.rst      (por_b_r),
		.set_bits (any_enabled & ~any_prev_r),
		.clr_bits (wr_glb_flag & wr_byte[`PWE_BIT_GLB]),
		.bits_r   (glb_flag)
	);

	assign wake_act = glb_en_r & glb_flag & any_enabled;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_request_out_n <= 1'b1;
		end else begin
			wake_request_out_n <= ~wake_act;
		end
	end

	// ----------------------------------------
	// interrupt status, clear and enable
	// ----------------------------------------
	logic [`PWE_IRQ_W-1:0] irq_set;
	logic [`PWE_IRQ_W-1:0] irq_sts;
	logic [`PWE_IRQ_W-1:0] irq_en_r;

	always_comb begin
		irq_set = `PWE_RST_IRQ;
		irq_set[`PWE_IRQ_BIT_EVENT] = |({ev_one, ev_two, ev_three});
		irq_set[`PWE_IRQ_BIT_WAKE]  = wake_act & wake_request_out_n;
	end

	pwe_sticky_bits #(
		.WIDTH (`PWE_IRQ_W)
	) u_irq_sts (
		.clk      (clk),
		.rst      (sys_rst),
		.set_bits (irq_set),
		.clr_bits (wr_irq_clr ? wr_byte[`PWE_IRQ_W-1:0] : `PWE_RST_IRQ),
		.bits_r   (irq_sts)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_en_r <= `PWE_RST_IRQ;
		end else if (wr_irq_en) begin
			irq_en_r <= wr_byte[`PWE_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_sts & irq_en_r);
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// unmapped and write-only indices read as zero
	always_comb begin
		rd_nxt = `PWE_RST_WORD;
		if (idx_is(reg_idx, `PWE_IDX_GLB_FLAG)) begin
			rd_nxt[0] = glb_flag;
		end else if (idx_is(reg_idx, `PWE_IDX_GLB_EN)) begin
			rd_nxt[0] = glb_en_r;
		end else if (idx_is(reg_idx, `PWE_IDX_STS_THREE)) begin
			rd_nxt[7:0] = sts_three;
		end else if (idx_is(reg_idx, `PWE_IDX_STS_TWO)) begin
			rd_nxt[7:0] = sts_two;
		end else if (idx_is(reg_idx, `PWE_IDX_STS_ONE)) begin
			rd_nxt[7:0] = sts_one;
		end else if (idx_is(reg_idx, `PWE_IDX_HOLE)) begin
			rd_nxt = `PWE_RST_WORD;
		end else if (idx_is(reg_idx, `PWE_IDX_EN_THREE)) begin
			rd_nxt[7:0] = en_three_r;
		end else if (idx_is(reg_idx, `PWE_IDX_EN_TWO)) begin
			rd_nxt[7:0] = en_two_r;
		end else if (idx_is(reg_idx, `PWE_IDX_EN_ONE)) begin
			rd_nxt[7:0] = en_one_r;
		end else if (idx_is(reg_idx, `PWE_IDX_IRQ_STS)) begin
			rd_nxt[`PWE_IRQ_W-1:0] = irq_sts;
		end else if (idx_is(reg_idx, `PWE_IDX_IRQ_EN)) begin
			rd_nxt[`PWE_IRQ_W-1:0] = irq_en_r;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_readdata <= `PWE_RST_WORD;
		end else if ((bus_state_r == pwe_pkg::PWE_BUS_IDLE) & avs_read) begin
			avs_readdata <= rd_nxt;
		end
	end

endmodule // pwe_wake_event_top

// >>> pwe_wake_event_top_asserts.sv
// port checker for the pwe wake event top
`timescale 1ns/1ps
module pwe_wake_event_top_asserts #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              standby_power_on_reset,
	// bus
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_writedata,
	input wire logic [3:0]        avs_byteenable,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	// outputs
	input wire logic              wake_request_out_n,
	input wire logic              irq
);
	// ----------------------------------------
	// shadows of enables seen on the bus
	// ----------------------------------------
	logic glb_r;
	logic ien_r;
	wire logic tk = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire logic [5:0] ix = avs_address[7:2];

	// cleared at once, the design two edges later; harmless while wake is idle
	always_ff @(posedge clk)
		if (standby_power_on_reset)
			glb_r <= 1'b0;
		else if (tk && ix == 6'h04)
			glb_r <= avs_writedata[0];

	always_ff @(posedge clk)
		if (sys_rst)
			ien_r <= 1'b0;
		else if (tk && ix == 6'h22)
			ien_r <= |avs_writedata[1:0];

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_flag_clr;
		tk && ix == 6'h00 && avs_writedata[0];
	endsequence
	sequence s_rd_done;
		avs_read && !avs_waitrequest;
	endsequence

	a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|-> ##[1:2] !avs_waitrequest) else $error("request not answered");
	a_wait_idle: assert property (!avs_read && !avs_write |-> avs_waitrequest)
		else $error("waitrequest low without request");
	a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> avs_waitrequest
		&& wake_request_out_n && !irq) else $error("outputs not idle after reset");
	a_glb_gates_wake: assert property (!wake_request_out_n |-> $past(glb_r))
		else $error("wake active with global enable clear");
	a_flag_clr_stop: assert property (s_flag_clr |=> ##1 wake_request_out_n)
		else $error("wake still active after flag clear");
	a_irq_gated: assert property (irq |-> $past(ien_r))
		else $error("irq high with no enable");
	a_hole_zero: assert property (s_rd_done ##0 ix == 6'h0b |-> avs_readdata == 32'h0000_0000)
		else $error("reserved hole read not zero");
	a_read_upper_zero: assert property (s_rd_done |-> avs_readdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
endmodule // pwe_wake_event_top_asserts

bind pwe_wake_event_top pwe_wake_event_top_asserts #(.ADDR_W(ADDR_W)) u_chk (
	.clk, .sys_rst, .standby_power_on_reset, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.wake_request_out_n, .irq);

// >>> pwe_wake_event_top_tb.sv
// self-checking testbench for the pwe wake event top
`timescale 1ns/1ps
module pwe_wake_event_top_tb;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic        clk     = 1'b0;
	logic        sys_rst = 1'b1;
	logic        sby     = 1'b0;
	logic [7:0]  adr     = 8'h00;
	logic        rd_en   = 1'b0;
	logic        wr_en   = 1'b0;
	logic [31:0] wd      = 32'h0000_0000;
	logic [3:0]  ben     = 4'h1;
	logic [3:0]  be      = 4'h1;
	logic [18:0] src     = 19'h0_0000;
	logic [1:0]  tach    = 2'b11;
	logic [31:0] rdata;
	logic        wait_q;
	logic        wake_n;
	logic        irq;
	logic [7:0]  cnt;
	int          err_count = 0;
	int          checks    = 0;
	logic [5:0]  ids [12] = '{6'h00, 6'h04, 6'h08, 6'h09, 6'h0a, 6'h0b,
		6'h0c, 6'h0d, 6'h0e, 6'h20, 6'h22, 6'h30};

	always #20 clk = ~clk;

	pwe_wake_event_top DUT (
		.clk, .sys_rst, .standby_power_on_reset(sby), .avs_address(adr),
		.avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wd), .avs_byteenable(ben),
		.avs_readdata(rdata), .avs_waitrequest(wait_q),
		.general_pin_group_one(src[7:0]), .general_pin_twenty(src[11:8]),
		.ring_indicate_two(src[12]), .ring_indicate_one(src[13]),
		.keyboard_wake_source(src[14]), .mouse_wake_source(src[15]),
		.specific_key_wake(src[16]), .fan_speed_input_one(src[17]),
		.fan_speed_input_two(src[18]), .fan_pin_tach_mode(tach),
		.wake_request_out_n(wake_n), .irq);
	pwe_wake_sink u_sink (.clk, .rst(sys_rst), .wake_n, .wake_cnt(cnt));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one edge first, so a release never meets a new request in one step
	task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= {i, 2'b00};
		rd_en <= !w;
		wr_en <= w;
		wd <= {24'h00_0000, d};
		ben <= be;
		do begin
			@(posedge clk);
			n++;
		end while (wait_q && n < 40);
		q = rdata[7:0];
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		if (n >= 40) begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, q);
	endtask
	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, i, 8'h00, q);
		chk(q, e);
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		src[b] <= 1'b1;
		cyc(2);
		src[b] <= 1'b0;
		cyc(6);
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		logic [7:0] e;
		cyc(2);
		sby <= 1'b1;
		cyc(4);
		sby <= 1'b0;
		cyc(10);
		sys_rst <= 1'b0;
		foreach (ids[k]) rd(ids[k], 8'h00);
		e = 8'h00;
		for (int n = 0; n < 8; n++) begin
			pulse(n);
			e[n] = 1'b1;
			rd(6'h09, e);
		end
		be = 4'h0;
		wr(6'h09, 8'hff);
		be = 4'h1;
		rd(6'h09, 8'hff);
		wr(6'h09, 8'h55);
		rd(6'h09, 8'haa);
		wr(6'h09, 8'haa);
		rd(6'h09, 8'h00);
		e = 8'h00;
		for (int k = 1; k < 8; k++) begin
			pulse(11 + k);
			e[k] = 1'b1;
			rd(6'h0a, e);
		end
		@(posedge clk);
		tach <= 2'b00;
		cyc(2);
		rd(6'h0a, 8'h3e);
		pulse(17);
		pulse(18);
		rd(6'h0a, 8'h3e);
		wr(6'h0a, 8'hff);
		rd(6'h0a, 8'h00);
		wr(6'h0c, 8'hff);
		rd(6'h0c, 8'h0f);
		pulse(8);
		rd(6'h08, 8'h01);
		wr(6'h08, 8'h01);
		rd(6'h08, 8'h00);
		wr(6'h04, 8'h01);
		wr(6'h0d, 8'h01);
		pulse(1);
		chk({7'h00, wake_n}, 8'h01);
		rd(6'h09, 8'h02);
		pulse(0);
		chk({7'h00, wake_n}, 8'h00);
		rd(6'h00, 8'h01);
		wr(6'h04, 8'h00);
		cyc(2);
		chk({7'h00, wake_n}, 8'h01);
		wr(6'h04, 8'h01);
		cyc(2);
		chk({7'h00, wake_n}, 8'h00);
		cyc(1);
		chk(cnt, 8'h02);
		wr(6'h00, 8'h01);
		cyc(2);
		chk({7'h00, wake_n}, 8'h01);
		rd(6'h00, 8'h00);
		// interrupt: raise, mask, unmask, clear
		wr(6'h22, 8'h01);
		cyc(2);
		chk({7'h00, irq}, 8'h01);
		wr(6'h22, 8'h00);
		cyc(2);
		chk({7'h00, irq}, 8'h00);
		wr(6'h22, 8'h03);
		cyc(2);
		chk({7'h00, irq}, 8'h01);
		wr(6'h21, 8'h03);
		cyc(2);
		chk({7'h00, irq}, 8'h00);
		rd(6'h20, 8'h00);
		rd(6'h21, 8'h00);
		rd(6'h22, 8'h03);
		// bus reset keeps wake state, standby reset clears it
		@(posedge clk);
		sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		rd(6'h09, 8'h03);
		rd(6'h0d, 8'h01);
		rd(6'h04, 8'h01);
		@(posedge clk);
		sby <= 1'b1;
		cyc(4);
		sby <= 1'b0;
		cyc(4);
		rd(6'h09, 8'h00);
		rd(6'h0d, 8'h00);
		rd(6'h04, 8'h00);
		wrap_up();
	end
endmodule // pwe_wake_event_top_tb

// >>> pwe_wake_sink.sv
// wake receiver model: counts wake requests seen on the line
`timescale 1ns/1ps
module pwe_wake_sink (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// wake line, push-pull, active low
	input  wire logic       wake_n,
	// requests observed
	output logic      [7:0] wake_cnt
);
	logic last_r;

	// counts falling edges only, so a held request is one request
	always_ff @(posedge clk) begin
		if (rst) begin
			last_r   <= 1'b1;
			wake_cnt <= 8'h00;
		end else begin
			last_r <= wake_n;
			if (last_r && !wake_n)
				wake_cnt <= wake_cnt + 8'h01;
		end
	end
endmodule // pwe_wake_sink
